// >>> design/power_mode_controller.sv
`include "pmc_cfg.svh"

// Behaviour
// RL1: Power-up enters full-on, PLL on, unbypassed
// RL2: Active keeps PLL enabled but bypassed
// RL3: Active allows DMA to configured L1
// RL4: PLL power-down bit disables PLL in active
// RL5: Sleep stops core clock, PLL/system run
// RL6: Enabled sleep wakeup picks full-on or active
// RL7: Sleep blocks system DMA to L1
// RL8: Deep sleep stops clocks; exit RTC/reset
// RL9: Deep sleep: RTC to active, reset full-on
// RL10: Deep sleep blocks async peripheral access
// RL11: Hibernate stops clocks, shuts core supply
// RL12: Hibernate puts external pins high impedance
// RL13: Hibernate exits on listed wakeup sources
// RL14: Hibernate wakeup starts full reset sequence
// RL15: Only regulator and RTC registers survive hibernate
// RL16: Media transceiver wakes from sleep
// RL17: Media network activity wakes from hibernate
// RL18: Low-power entry only by software request
module power_mode_controller (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    // Reset pin from outside, active low
    input  wire logic                     resetPin_n,
    // Software control bits
    input  wire logic                     pllBypassBit,
    input  wire logic                     pllOffBit,
    input  wire logic                     wakeEnWrite,
    input  wire logic [`WAKE_WIDTH-1:0]   wakeEnData,
    input  wire logic                     vregWrite,
    input  wire logic [`VREG_WIDTH-1:0]   vregData,
    input  wire logic                     vregShutdownBit,
    input  wire logic                     enterActive,
    input  wire logic                     enterFullOn,
    input  wire pmc_pkg::pm_req_t         lowPowerReq,
    // Wakeup lines from on-chip sources, asynchronous
    input  wire logic [`WAKE_WIDTH-1:0]   wakeRaw,
    // Clock and power controls
    output pmc_pkg::pm_ctrl_t             ctrl_r,
    output pmc_pkg::pm_state_t            state_r,
    output logic                          coreResetReq_r,
    output logic [`WAKE_WIDTH-1:0]        wakeEn_r,
    output logic [`VREG_WIDTH-1:0]        vreg_r,
    output logic                          volatileClear_r
);
    localparam int unsigned SEQ_LEN = `RESET_SEQ_CYCLES;

    logic [`WAKE_WIDTH-1:0] wakeRise;
    logic                   resetPinLow;
    logic                   sleepWake;
    logic                   hibWake;
    logic [7:0]             seqCnt_r;
    pmc_pkg::pm_state_t     state_nxt;
    pmc_pkg::pm_ctrl_t      ctrl_nxt;

    // One synchroniser and edge detector per wakeup line
    genvar gi;
    generate
        for (gi = 0; gi < `WAKE_WIDTH; gi++) begin : g_wake
            wake_edge u_edge (
                .mclk      (mclk),
                .reset_n   (reset_n),
                .rawIn     (wakeRaw[gi]),
                .risePulse (wakeRise[gi])
            );
        end
    endgenerate

    // Reset pin comes from outside the clock domain. It is inverted before the
    // flops so that their cleared value means pin released: a cleared active-low
    // copy would read as a pin reset for two cycles after every reset and throw
    // an early sleep request straight back to full-on.
    sync2 u_rstpin (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (~resetPin_n),
        .dout    (resetPinLow)
    );

    // Any enabled source, media events included, wakes sleep
    assign sleepWake = |(wakeRise & wakeEn_r);                    // [RL6] [RL16]

    // Hibernate wakeups do not need the volatile enable mask, which is lost
    assign hibWake = wakeRise[`WAKE_CAN]
                   | wakeRise[`WAKE_MEDIA_NET]
                   | wakeRise[`WAKE_KEYPAD]
                   | wakeRise[`WAKE_COUNTER]
                   | wakeRise[`WAKE_USB]
                   | wakeRise[`WAKE_GPIO]
                   | wakeRise[`WAKE_RTC];                         // [RL13] [RL17]

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pmc_pkg::PM_FULL_ON: begin
                if (pllBypassBit && enterActive) begin
                    state_nxt = pmc_pkg::PM_ACTIVE;
                end else begin
                    // Low-power entry only on explicit software request
                    unique case (lowPowerReq)                     // [RL18]
                        pmc_pkg::REQ_SLEEP:      state_nxt = pmc_pkg::PM_SLEEP;
                        pmc_pkg::REQ_DEEP_SLEEP: state_nxt = pmc_pkg::PM_DEEP_SLEEP;
                        pmc_pkg::REQ_HIBERNATE: begin
                            if (vregShutdownBit) begin
                                state_nxt = pmc_pkg::PM_HIBERNATE;
                            end
                        end
                        pmc_pkg::REQ_NONE:       state_nxt = state_r;
                    endcase
                end
            end
            pmc_pkg::PM_ACTIVE: begin
                // PLL must be back on before full-on or sleep
                if (enterFullOn && !pllBypassBit && !pllOffBit) begin
                    state_nxt = pmc_pkg::PM_FULL_ON;              // [RL4]
                end else begin
                    unique case (lowPowerReq)                     // [RL18]
                        pmc_pkg::REQ_SLEEP: begin
                            if (!pllOffBit) begin
                                state_nxt = pmc_pkg::PM_SLEEP;    // [RL4]
                            end
                        end
                        pmc_pkg::REQ_DEEP_SLEEP: state_nxt = pmc_pkg::PM_DEEP_SLEEP;
                        pmc_pkg::REQ_HIBERNATE: begin
                            if (vregShutdownBit) begin
                                state_nxt = pmc_pkg::PM_HIBERNATE;
                            end
                        end
                        pmc_pkg::REQ_NONE:       state_nxt = state_r;
                    endcase
                end
            end
            pmc_pkg::PM_SLEEP: begin
                if (resetPinLow) begin
                    state_nxt = pmc_pkg::PM_FULL_ON;
                end else if (sleepWake) begin
                    // Bypass bit sampled at the wakeup
                    state_nxt = pllBypassBit ? pmc_pkg::PM_ACTIVE
                                             : pmc_pkg::PM_FULL_ON; // [RL6]
                end
            end
            pmc_pkg::PM_DEEP_SLEEP: begin
                // Reset wins over a simultaneous RTC interrupt
                if (resetPinLow) begin
                    state_nxt = pmc_pkg::PM_FULL_ON;              // [RL9]
                end else if (wakeRise[`WAKE_RTC]) begin
                    state_nxt = pmc_pkg::PM_ACTIVE;               // [RL8] [RL9]
                end
            end
            pmc_pkg::PM_HIBERNATE: begin
                if (resetPinLow || hibWake) begin
                    state_nxt = pmc_pkg::PM_RESET_SEQ;            // [RL13] [RL14]
                end
            end
            pmc_pkg::PM_RESET_SEQ: begin
                if (seqCnt_r == 8'(SEQ_LEN - 1)) begin
                    state_nxt = pmc_pkg::PM_FULL_ON;              // [RL14]
                end
            end
            // Codes 6 and 7 are unused; recover to the power-up state
            default: begin
                state_nxt = pmc_pkg::PM_FULL_ON;
            end
        endcase
    end

    // Controls that follow the next state
    always_comb begin
        ctrl_nxt = '0;
        unique case (state_nxt)
            pmc_pkg::PM_FULL_ON: begin
                // PLL locked and in the path, every clock at full rate
                ctrl_nxt.pllEnable    = 1'b1;                     // [RL1]
                ctrl_nxt.coreClkEn    = 1'b1;
                ctrl_nxt.sysClkEn     = 1'b1;
                ctrl_nxt.coreSupplyOn = 1'b1;
                ctrl_nxt.dmaL1Allow   = 1'b1;
            end
            pmc_pkg::PM_ACTIVE: begin
                ctrl_nxt.pllEnable    = ~pllOffBit;               // [RL2] [RL4]
                ctrl_nxt.pllBypass    = 1'b1;                     // [RL2]
                ctrl_nxt.coreClkEn    = 1'b1;
                ctrl_nxt.sysClkEn     = 1'b1;
                ctrl_nxt.coreSupplyOn = 1'b1;
                ctrl_nxt.dmaL1Allow   = 1'b1;                     // [RL3]
            end
            pmc_pkg::PM_SLEEP: begin
                // Bypass held so a wake to active needs no relock
                ctrl_nxt.pllEnable    = 1'b1;                     // [RL5]
                ctrl_nxt.pllBypass    = pllBypassBit;
                ctrl_nxt.sysClkEn     = 1'b1;                     // [RL5]
                ctrl_nxt.coreSupplyOn = 1'b1;
                ctrl_nxt.dmaL1Allow   = 1'b0;                     // [RL7]
            end
            pmc_pkg::PM_DEEP_SLEEP: begin
                // PLL and both clocks off; only the RTC domain keeps running
                ctrl_nxt.coreSupplyOn = 1'b1;                     // [RL8]
                ctrl_nxt.asyncBlock   = 1'b1;                     // [RL10]
            end
            pmc_pkg::PM_HIBERNATE: begin
                // Core supply off; floating pins draw nothing from powered neighbours
                ctrl_nxt.regShutdown  = 1'b1;                     // [RL11]
                ctrl_nxt.pinsHighZ    = 1'b1;                     // [RL12]
                ctrl_nxt.asyncBlock   = 1'b1;
            end
            pmc_pkg::PM_RESET_SEQ: begin
                // Supply back on, clocks held while the core is in reset
                ctrl_nxt.coreSupplyOn = 1'b1;
                ctrl_nxt.pinsHighZ    = 1'b1;
                ctrl_nxt.asyncBlock   = 1'b1;
            end
            // Unreachable once the next state is recovered; all off is safe
            default: begin
                ctrl_nxt = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_r <= pmc_pkg::PM_FULL_ON;                       // [RL1]
        end else begin
            state_r <= state_nxt;
        end
    end

    // Control register, loaded from the next state so it always matches state_r
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_r <= '{pllEnable:    1'b1,                       // [RL1]
                        pllBypass:    1'b0,
                        coreClkEn:    1'b1,
                        sysClkEn:     1'b1,
                        coreSupplyOn: 1'b1,
                        regShutdown:  1'b0,
                        pinsHighZ:    1'b0,
                        dmaL1Allow:   1'b1,
                        asyncBlock:   1'b0};
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Reset sequence counter; it restarts from zero on every entry, so a
    // second wakeup always gets the full sequence
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            seqCnt_r <= 8'h00;
        end else if (state_r == pmc_pkg::PM_RESET_SEQ) begin
            seqCnt_r <= seqCnt_r + 8'h01;
        end else begin
            seqCnt_r <= 8'h00;
        end
    end

    // Core reset held through hibernate and the reset sequence; releasing it
    // only at the end of the sequence means no prior execution is resumed
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            coreResetReq_r <= 1'b0;
        end else begin
            coreResetReq_r <= (state_nxt == pmc_pkg::PM_HIBERNATE)
                           || (state_nxt == pmc_pkg::PM_RESET_SEQ);   // [RL14]
        end
    end

    // Tells the rest of the core that its registers and memories are lost
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            volatileClear_r <= 1'b0;
        end else begin
            volatileClear_r <= (state_nxt == pmc_pkg::PM_HIBERNATE);  // [RL15]
        end
    end

    // Wakeup enables are volatile and cleared by hibernate,
    // so a stale mask cannot wake a later sleep
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wakeEn_r <= `WAKE_EN_RESET;
        end else if (state_r == pmc_pkg::PM_HIBERNATE) begin
            wakeEn_r <= `WAKE_EN_RESET;                           // [RL15]
        end else if (wakeEnWrite) begin
            wakeEn_r <= wakeEnData;
        end
    end

    // Regulator control keeps its value across hibernate;
    // writes are refused while the core is unpowered
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vreg_r <= `VREG_RESET;
        end else if (vregWrite && state_r != pmc_pkg::PM_HIBERNATE) begin
            vreg_r <= vregData;                                   // [RL15]
        end
    end
endmodule // power_mode_controller

// >>> design/pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Wakeup source bit positions in the wakeup vectors
`define WAKE_CAN        0
`define WAKE_MEDIA      1
`define WAKE_KEYPAD     2
`define WAKE_COUNTER    3
`define WAKE_USB        4
`define WAKE_GPIO       5
`define WAKE_RTC        6
`define WAKE_MEDIA_NET  7
`define WAKE_WIDTH      8

// Wakeup enable reset value: all sources masked
`define WAKE_EN_RESET   8'h00

// Regulator control register width and reset value
`define VREG_WIDTH      8
`define VREG_RESET      8'h00

// Cycles the hardware reset sequence lasts after a hibernate wakeup
`define RESET_SEQ_NS     160
`define RESET_SEQ_CYCLES ((`RESET_SEQ_NS + 9) / 10)

`endif

// >>> design/pmc_pkg.sv
package pmc_pkg;

    typedef enum logic [2:0] {
        PM_FULL_ON,
        PM_ACTIVE,
        PM_SLEEP,
        PM_DEEP_SLEEP,
        PM_HIBERNATE,
        PM_RESET_SEQ
    } pm_state_t;

    typedef enum logic [1:0] {
        REQ_NONE,
        REQ_SLEEP,
        REQ_DEEP_SLEEP,
        REQ_HIBERNATE
    } pm_req_t;

    // Clock and power controls that leave the block together
    typedef struct packed {
        logic pllEnable;
        logic pllBypass;
        logic coreClkEn;
        logic sysClkEn;
        logic coreSupplyOn;
        logic regShutdown;
        logic pinsHighZ;
        logic dmaL1Allow;
        logic asyncBlock;
    } pm_ctrl_t;

endpackage

// >>> design/sync2.sv
// Two-flop synchroniser for pin-level inputs
module sync2 (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      dout
);
    logic stage_r;

    // First stage is read only by the second
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stage_r <= 1'b0;
            dout    <= 1'b0;
        end else begin
            stage_r <= din;
            dout    <= stage_r;
        end
    end
endmodule // sync2

// >>> design/wake_edge.sv
`include "pmc_cfg.svh"

// Synchronises one wakeup line and reports its rising edge
module wake_edge (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic rawIn,
    output logic      risePulse
);
    logic syncLvl;
    logic prev_r;

    sync2 u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (rawIn),
        .dout    (syncLvl)
    );

    // Edge detection on the synchronised level only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= syncLvl;
        end
    end

    assign risePulse = syncLvl & ~prev_r;
endmodule // wake_edge

// >>> verif/pmc_checker_sva.sv
`include "pmc_cfg.svh"

// Watches the mode sequencer from its ports only
module pmc_checker (
    // Clock, reset and software bits
    input wire logic                   mclk,
    input wire logic                   reset_n,
    input wire logic                   pllBypassBit,
    input wire logic                   vregShutdownBit,
    input wire pmc_pkg::pm_req_t       lowPowerReq,
    // Outputs under watch
    input wire pmc_pkg::pm_ctrl_t      ctrl_r,
    input wire pmc_pkg::pm_state_t     state_r,
    input wire logic                   coreResetReq_r,
    input wire logic [`VREG_WIDTH-1:0] vreg_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic inFull, inAct, inSlp, inDeep, inHib, inSeq;
    // Decoded state flags keep the properties short
    assign inFull = state_r == pmc_pkg::PM_FULL_ON;
    assign inAct = state_r == pmc_pkg::PM_ACTIVE;
    assign inSlp = state_r == pmc_pkg::PM_SLEEP;
    assign inDeep = state_r == pmc_pkg::PM_DEEP_SLEEP;
    assign inHib = state_r == pmc_pkg::PM_HIBERNATE;
    assign inSeq = state_r == pmc_pkg::PM_RESET_SEQ;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Half of the reset sequence; two back to back cover all of it
    sequence s_seqHold;
        inSeq [*8];
    endsequence
    a_full_ctrl: assert property (inFull |-> ctrl_r.pllEnable && !ctrl_r.pllBypass
        && ctrl_r.coreClkEn && ctrl_r.sysClkEn) else $error("full-on controls wrong");
    a_act_bypass: assert property (inAct |-> ctrl_r.pllBypass && ctrl_r.sysClkEn
        && ctrl_r.dmaL1Allow) else $error("active controls wrong");
    a_slp_clocks: assert property (inSlp |-> !ctrl_r.coreClkEn && ctrl_r.sysClkEn
        && ctrl_r.pllEnable && !ctrl_r.dmaL1Allow) else $error("sleep controls wrong");
    a_deep_clocks: assert property (inDeep |-> !ctrl_r.coreClkEn
        && !ctrl_r.sysClkEn && ctrl_r.asyncBlock) else $error("deep sleep controls wrong");
    a_hib_power: assert property (inHib |-> !ctrl_r.coreSupplyOn && ctrl_r.regShutdown
        && ctrl_r.pinsHighZ && coreResetReq_r) else $error("hibernate controls wrong");
    a_slp_exit: assert property (inSlp ##1 !inSlp |-> inFull
        || (inAct && $past(pllBypassBit))) else $error("bad sleep exit");
    a_deep_exit: assert property (inDeep ##1 !inDeep |-> inAct || inFull)
        else $error("bad deep sleep exit");
    a_slp_entry: assert property ($rose(inSlp) |->
        $past(lowPowerReq) == pmc_pkg::REQ_SLEEP) else $error("sleep without request");
    a_hib_entry: assert property ($rose(inHib) |-> $past(vregShutdownBit)
        && $past(lowPowerReq) == pmc_pkg::REQ_HIBERNATE) else $error("bad hibernate entry");
    a_vreg_keep: assert property (inHib && $past(inHib) |-> $stable(vreg_r))
        else $error("regulator value changed");
    a_seq_len: assert property ($rose(inSeq) |-> s_seqHold ##1 s_seqHold ##1 inFull)
        else $error("reset sequence length wrong");
endmodule // pmc_checker

// >>> verif/wake_src_model.sv
`include "pmc_cfg.svh"

// On-chip wakeup sources and the reset pin
module wake_src_model (
    // Clock
    input wire logic             mclk,
    // Lines into the block
    output logic [`WAKE_WIDTH-1:0] wakeRaw,
    output logic                 resetPin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wakeRaw = '0;
        resetPin_n = 1'b1;
    end
    // Four cycles high so the two-flop synchroniser cannot miss it
    task automatic pulse(input int b);
        wakeRaw[b] = 1'b1;
        repeat (4) @(posedge mclk);
        #1 wakeRaw[b] = 1'b0;
    endtask
    // Pin low long enough to pass both sync flops
    task automatic pinReset();
        resetPin_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1 resetPin_n = 1'b1;
    endtask
endmodule // wake_src_model

// >>> verif/tb_top.sv
`include "pmc_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, pllBypassBit, pllOffBit, wakeEnWrite, vregWrite;
    logic vregShutdownBit, enterActive, enterFullOn, resetPin_n;
    logic coreResetReq_r, volatileClear_r;
    logic [7:0] wakeEnData, vregData, wakeRaw, wakeEn_r, vreg_r;
    pmc_pkg::pm_req_t lowPowerReq;
    pmc_pkg::pm_ctrl_t ctrl_r;
    pmc_pkg::pm_state_t state_r;
    int fails, n_compared;

    power_mode_controller i_dut (.mclk(mclk), .reset_n(reset_n), .resetPin_n(resetPin_n),
        .pllBypassBit(pllBypassBit), .pllOffBit(pllOffBit), .wakeEnWrite(wakeEnWrite),
        .wakeEnData(wakeEnData), .vregWrite(vregWrite), .vregData(vregData),
        .vregShutdownBit(vregShutdownBit), .enterActive(enterActive),
        .enterFullOn(enterFullOn), .lowPowerReq(lowPowerReq), .wakeRaw(wakeRaw),
        .ctrl_r(ctrl_r), .state_r(state_r), .coreResetReq_r(coreResetReq_r),
        .wakeEn_r(wakeEn_r), .vreg_r(vreg_r), .volatileClear_r(volatileClear_r));
    wake_src_model i_src (.mclk(mclk), .wakeRaw(wakeRaw), .resetPin_n(resetPin_n));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Only an explicit request moves the block into a low-power state
    task req(input pmc_pkg::pm_req_t r);
        lowPowerReq = r;
        step(1);
        lowPowerReq = pmc_pkg::REQ_NONE;
    endtask
    // Bounded wait; the caller judges the state reached
    task goWait(input pmc_pkg::pm_state_t s);
        for (int i = 0; i < 40 && state_r !== s; i++) step(1);
    endtask
    task backFull();
        pllBypassBit = 1'b0;
        pllOffBit = 1'b0;
        enterFullOn = 1'b1;
        goWait(pmc_pkg::PM_FULL_ON);
        enterFullOn = 1'b0;
        `CHK(state_r, pmc_pkg::PM_FULL_ON)
    endtask
    task wrWake(input logic [7:0] v);
        wakeEnData = v;
        wakeEnWrite = 1'b1;
        step(1);
        wakeEnWrite = 1'b0;
    endtask

    task t_reset();
        `CHK(ctrl_r, 9'h172)
        `CHK(wakeEn_r, 8'h00)
        req(pmc_pkg::REQ_SLEEP);
        step(3);
        `CHK(state_r, pmc_pkg::PM_SLEEP)
        i_src.pinReset();
        goWait(pmc_pkg::PM_FULL_ON);
        `CHK(state_r, pmc_pkg::PM_FULL_ON)
        $display("test reset done");
    endtask
    task t_active();
        pllBypassBit = 1'b1;
        enterActive = 1'b1;
        goWait(pmc_pkg::PM_ACTIVE);
        enterActive = 1'b0;
        `CHK(state_r, pmc_pkg::PM_ACTIVE)
        `CHK(ctrl_r.dmaL1Allow, 1'b1)
        pllOffBit = 1'b1;
        step(2);
        `CHK(ctrl_r.pllEnable, 1'b0)
        req(pmc_pkg::REQ_SLEEP);
        pllBypassBit = 1'b0;
        enterFullOn = 1'b1;
        step(3);
        enterFullOn = 1'b0;
        `CHK(state_r, pmc_pkg::PM_ACTIVE)
        backFull();
        $display("test active done");
    endtask
    // Masked line must not wake; enabled media event picks by bypass
    task t_sleep(input logic byp);
        pmc_pkg::pm_state_t exp;
        exp = byp ? pmc_pkg::PM_ACTIVE : pmc_pkg::PM_FULL_ON;
        wrWake(8'h02);
        pllBypassBit = byp;
        req(pmc_pkg::REQ_SLEEP);
        goWait(pmc_pkg::PM_SLEEP);
        `CHK(ctrl_r.coreClkEn, 1'b0)
        `CHK(ctrl_r.dmaL1Allow, 1'b0)
        i_src.pulse(0);
        step(4);
        `CHK(state_r, pmc_pkg::PM_SLEEP)
        i_src.pulse(1);
        goWait(exp);
        `CHK(state_r, exp)
        backFull();
        $display("test sleep done");
    endtask
    task t_deep();
        wrWake(8'hFF);
        req(pmc_pkg::REQ_DEEP_SLEEP);
        goWait(pmc_pkg::PM_DEEP_SLEEP);
        `CHK(ctrl_r.sysClkEn, 1'b0)
        `CHK(ctrl_r.asyncBlock, 1'b1)
        i_src.pulse(2);
        step(4);
        `CHK(state_r, pmc_pkg::PM_DEEP_SLEEP)
        i_src.pulse(6);
        goWait(pmc_pkg::PM_ACTIVE);
        `CHK(state_r, pmc_pkg::PM_ACTIVE)
        backFull();
        req(pmc_pkg::REQ_DEEP_SLEEP);
        goWait(pmc_pkg::PM_DEEP_SLEEP);
        i_src.pinReset();
        goWait(pmc_pkg::PM_FULL_ON);
        `CHK(state_r, pmc_pkg::PM_FULL_ON)
        $display("test deep sleep done");
    endtask
    // Every hibernate source in turn, index 8 standing for the reset pin
    task t_hib();
        vregData = 8'hA5;
        vregWrite = 1'b1;
        step(1);
        vregWrite = 1'b0;
        req(pmc_pkg::REQ_HIBERNATE);
        step(3);
        `CHK(state_r, pmc_pkg::PM_FULL_ON)
        vregShutdownBit = 1'b1;
        for (int b = 0; b < 9; b++) begin
            if (b == 1) continue;
            req(pmc_pkg::REQ_HIBERNATE);
            goWait(pmc_pkg::PM_HIBERNATE);
            `CHK(ctrl_r.coreSupplyOn, 1'b0)
            `CHK(ctrl_r.pinsHighZ, 1'b1)
            `CHK(volatileClear_r, 1'b1)
            vregData = 8'h3C;
            vregWrite = 1'b1;
            i_src.pulse(1);
            vregWrite = 1'b0;
            `CHK(state_r, pmc_pkg::PM_HIBERNATE)
            if (b == 8) i_src.pinReset();
            else i_src.pulse(b);
            goWait(pmc_pkg::PM_RESET_SEQ);
            `CHK(coreResetReq_r, 1'b1)
            goWait(pmc_pkg::PM_FULL_ON);
            `CHK(state_r, pmc_pkg::PM_FULL_ON)
            `CHK(vreg_r, 8'hA5)
            `CHK(wakeEn_r, 8'h00)
            `CHK(volatileClear_r, 1'b0)
        end
        vregShutdownBit = 1'b0;
        $display("test hibernate done");
    endtask

    task end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {reset_n, pllBypassBit, pllOffBit, wakeEnWrite, vregWrite} = '0;
        {vregShutdownBit, enterActive, enterFullOn, wakeEnData, vregData} = '0;
        lowPowerReq = pmc_pkg::REQ_NONE;
        step(8);
        reset_n = 1'b1;
        t_reset();
        t_active();
        t_sleep(1'b0);
        t_sleep(1'b1);
        t_deep();
        t_hib();
        end_of_test();
    end
    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule // tb_top

bind power_mode_controller pmc_checker i_chk (.mclk(mclk), .reset_n(reset_n),
    .pllBypassBit(pllBypassBit), .vregShutdownBit(vregShutdownBit),
    .lowPowerReq(lowPowerReq), .ctrl_r(ctrl_r), .state_r(state_r),
    .coreResetReq_r(coreResetReq_r), .vreg_r(vreg_r));
